// *** bench/pin_control_pulse_timing_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module pin_control_pulse_timing_bench
  import pin_timing_pkg::*;
;
  // ===========================================================================
  // shortened counts, so nap and measurement fit a short run
  // ===========================================================================
  localparam int F = 4;
  localparam int M = 20;
  localparam int N = 30;
  localparam int W = 10;
  localparam int E = 2000;
  logic          core_clk = 1'b0;
  logic          reset = 1'b1;
  logic [4:0]    avs_address = 5'h00;
  logic          avs_read = 1'b0;
  logic          avs_write = 1'b0;
  logic [31:0]   avs_writedata = 32'h00000000;
  logic [3:0]    avs_byteenable = 4'hF;
  logic [31:0]   avs_readdata;
  logic          avs_waitrequest;
  logic [15:0]   pin_in;
  pin_drive_type pin_drive;
  logic          busy;
  logic [15:0]   ext_en = 16'h0000;
  logic [15:0]   ext_val = 16'h0000;
  int            errors = 0;
  int            checks_done = 0;

  // ===========================================================================
  // clock, device and loads
  // ===========================================================================
  always #4 core_clk = ~core_clk;
  pin_control_pulse_timing #(.FETCH_CYCLES_P(F), .MS_CYCLES_P(M), .NAP_BASE_CYCLES_P(N),
    .WAKE_GLITCH_CYCLES_P(W), .EDGE_TIMEOUT_CYCLES_P(E)) uut (
    .core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in),
    .pin_drive(pin_drive), .busy(busy));
  pin_load_model loads (.pin_drive(pin_drive), .ext_en(ext_en), .ext_val(ext_val),
    .pin_in(pin_in));

  // ===========================================================================
  // helpers
  // ===========================================================================
  task automatic complete_run;
    if (errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // counts are judged within a small slack, the sequencer edges are not pinned
  task automatic near(input string what, input int seen, input int exp, input int tol);
    check(what, (seen >= exp - tol && seen <= exp + tol) ? exp : seen, exp);
  endtask
  // one bus cycle; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    // judged at the rising edge itself; only the hang guard ends a stuck wait
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h00000000, 4'hF, q);
  endtask
  function automatic logic [31:0] mk(input logic [2:0] op, input int p, input logic lv,
                                     input logic bm, input int arg);
    cmd_type c;
    c = '0;
    c.op = op;
    c.pin = 4'(p);
    c.level = lv;
    c.byte_mode = bm;
    c.arg = 16'(arg);
    return c;
  endfunction
  // cycles that busy stays high after a command is taken
  task automatic busy_len(output int n);
    n = 0;
    @(negedge core_clk);
    while (busy === 1'b1 && n < 20000) begin
      n++;
      @(negedge core_clk);
    end
  endtask
  task automatic cmd(input logic [2:0] op, input int p, input logic lv, input logic bm,
                     input int arg, output int n);
    wr(COMMAND_OFFSET, mk(op, p, lv, bm, arg));
    busy_len(n);
  endtask

  // ===========================================================================
  // hang guard
  // ===========================================================================
  initial begin
    repeat (95000) @(posedge core_clk);
    errors++;
    complete_run;
  end

  // ===========================================================================
  // main sequence
  // ===========================================================================
  initial begin
    logic [31:0] q;
    logic [15:0] lat;
    logic [15:0] dir;
    int          p;
    int          n;
    int          g;
    int          st;
    int          w;
    logic        lv;
    void'($urandom(17));
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    // reset state and an unmapped address
    rd(DIRECTION_OFFSET, q); check("dir_reset", q, {16'h0000, DIRECTION_RESET});
    rd(OUTPUT_LATCH_OFFSET, q); check("lat_reset", q, 32'h00000000);
    check("oe_reset", {16'h0000, pin_drive.oe_n}, 32'h0000FFFF);
    rd(5'h18, q); check("unmapped", q, 32'h00000000);
    // drive-low and make-output alternate, end pins first
    dir = 16'h0000;
    lat = 16'($urandom);
    wr(OUTPUT_LATCH_OFFSET, {16'h0000, lat});
    for (int i = 0; i < 8; i++) begin
      p = (i < 2) ? i * 15 : $urandom_range(15);
      cmd(i[0] ? OP_MAKE_OUTPUT : OP_DRIVE_LOW, p, 1'b0, 1'b0, 0, n);
      dir[p] = 1'b1;
      if (!i[0]) lat[p] = 1'b0;
      rd(DIRECTION_OFFSET, q); check("dir_bits", q, {16'h0000, dir});
      rd(OUTPUT_LATCH_OFFSET, q); check("lat_bits", q, {16'h0000, lat});
      check("oe_bits", {16'h0000, pin_drive.oe_n}, {16'h0000, ~dir});
      check("pin_level", {31'h0, pin_in[p]}, {31'h0, lat[p]});
    end
    // a command with partial byte lanes is dropped
    wr(COMMAND_OFFSET, mk(OP_DRIVE_LOW, 0, 1'b0, 1'b0, 0), 4'h3);
    @(negedge core_clk);
    check("refused", {31'h0, busy}, 32'h00000000);
    cmd(OP_RESTART, 0, 1'b0, 1'b0, 0, n);
    rd(DIRECTION_OFFSET, q); check("restart", q, 32'h00000000);
    // delays, zero and random
    for (int i = 0; i < 3; i++) begin
      w = (i == 0) ? 0 : $urandom_range(6, 1);
      cmd(OP_DELAY, 0, 1'b0, 1'b0, w, n);
      near("delay_len", n, F + w * M, 2);
    end
    // every nap period with pin 0 driving; the wake glitch frees all pins
    cmd(OP_DRIVE_LOW, 0, 1'b0, 1'b0, 0, n);
    dir = 16'h0001;
    for (int k = 0; k < 8; k++) begin
      wr(COMMAND_OFFSET, mk(OP_NAP, 0, 1'b0, 1'b0, k));
      n = 0;
      g = 0;
      st = 0;
      do begin
        @(negedge core_clk);
        n++;
        if (pin_drive.oe_n === 16'hFFFF) begin
          g++;
          if (st == 0) st = n;
        end
      end while (!(busy === 1'b0 && g > 0 && pin_drive.oe_n !== 16'hFFFF) && n < 9000);
      near("nap_len", st, F + (N << k), 3);
      near("glitch_len", g, W, 1);
      check("restored", {16'h0000, pin_drive.oe_n}, {16'h0000, ~dir});
    end
    // pulse widths: low, high, long byte result, level already present
    for (int c = 0; c < 4; c++) begin
      lv = (c == 1);
      w = (c == 2) ? 258 : $urandom_range(6, 1);
      p = $urandom_range(15);
      cmd(OP_DRIVE_LOW, p, 1'b0, 1'b0, 0, n);
      @(posedge core_clk);
      ext_en[p] <= 1'b1;
      ext_val[p] <= (c == 3) ? lv : !lv;
      wr(COMMAND_OFFSET, mk(OP_MEASURE, p, lv, c == 2, 0));
      rd(DIRECTION_OFFSET, q); check("meas_input", {31'h0, q[p]}, 32'h00000000);
      if (c != 3) begin
        repeat (20) @(posedge core_clk);
        ext_val[p] <= lv;
        repeat (w * 250 + 125) @(posedge core_clk);
        ext_val[p] <= !lv;
      end
      busy_len(n);
      rd(RESULT_OFFSET, q);
      check("width", q, (c == 3) ? 0 : (c == 2) ? (w & 255) : w);
      rd(STATUS_OFFSET, q); check("zero_flag", {31'h0, q[STATUS_ZERO_BIT]}, c == 3);
      rd(DIRECTION_OFFSET, q); check("left_input", {31'h0, q[p]}, 32'h00000000);
      ext_en[p] <= 1'b0;
    end
    complete_run;
  end
endmodule // pin_control_pulse_timing_bench
`default_nettype wire

// *** bench/pin_load_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ===========================================================================
// external circuits on the pins: pulled lines plus a source the bench steers
// ===========================================================================
module pin_load_model
  import pin_timing_pkg::*;
#(
  parameter logic [15:0] PULL_LEVEL = 16'hFFFF
) (
  input  wire pin_drive_type pin_drive,
  input  wire logic [15:0]   ext_en,
  input  wire logic [15:0]   ext_val,
  output logic [15:0]        pin_in
);
  // the device driver wins, then the bench source; a released, unsourced line falls back to its resistor,
  // so a stale driven value never lingers on an undriven pin
  always_comb begin
    for (int n = 0; n < 16; n++) begin
      if (!pin_drive.oe_n[n]) pin_in[n] = pin_drive.out[n];
      else if (ext_en[n]) pin_in[n] = ext_val[n];
      else pin_in[n] = PULL_LEVEL[n];
    end
  end
endmodule // pin_load_model
`default_nettype wire

// *** verilog/pin_control_pulse_timing.sv ***
`timescale 1ns/1ns
`default_nettype none
module pin_control_pulse_timing
  import pin_timing_pkg::*;
#(
  parameter int FETCH_CYCLES_P        = FETCH_CYCLES,
  parameter int MS_CYCLES_P           = MS_CYCLES,
  parameter int NAP_BASE_CYCLES_P     = NAP_BASE_CYCLES,
  parameter int WAKE_GLITCH_CYCLES_P  = WAKE_GLITCH_CYCLES,
  parameter int EDGE_TIMEOUT_CYCLES_P = EDGE_TIMEOUT_CYCLES
) (
  input  wire logic          core_clk,
  input  wire logic          reset,
  input  wire logic [4:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  input  wire logic [3:0]    avs_byteenable,
  output logic [31:0]        avs_readdata,
  output logic               avs_waitrequest,
  input  wire logic [15:0]   pin_in,
  output pin_drive_type      pin_drive,
  output logic               busy
);

  // ===========================================================================
  // helpers
  // ===========================================================================
  // merge the low two byte lanes of a write into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] wdata,
                                          input logic [3:0]  be);
    logic [15:0] v;
    v = old_v;
    if (be[0]) begin
      v[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      v[15:8] = wdata[15:8];
    end
    return v;
  endfunction

  // one-hot mask for a pin index
  function automatic logic [15:0] pin_mask(input logic [3:0] idx);
    return 16'h0001 << idx;
  endfunction

  state_type q;
  state_type d;
  cmd_type   cmd;
  logic      req;
  logic      acc_write;
  logic      lvl;

  assign cmd       = cmd_type'(avs_writedata);
  assign req       = avs_read | avs_write;
  assign acc_write = avs_write & q.ack;
  assign lvl       = q.filt[q.pin];

  // ===========================================================================
  // bus answer and pin outputs
  // ===========================================================================
  // one wait state on every access keeps read data registered
  assign avs_waitrequest = req & ~q.ack;
  assign avs_readdata    = q.readdata;
  assign busy            = (q.fsm != ST_IDLE);
  assign pin_drive.out   = q.outs;
  // the wake glitch overrides every direction bit without losing them
  assign pin_drive.oe_n  = ~q.dirs | {16{q.glitch}};

  // ===========================================================================
  // next state
  // ===========================================================================
  always_comb begin
    d = q;
    // three-stage synchroniser; a change counts once stages two and three agree
    d.sync1 = pin_in;
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    for (int i = 0; i < 16; i++) begin
      if (q.sync2[i] == q.sync3[i]) begin
        d.filt[i] = q.sync3[i];
      end
    end

    // bus slave: ack one cycle after the request appears
    d.ack = req & ~q.ack;
    if (req && !q.ack) begin
      unique case (avs_address)
        DIRECTION_OFFSET:    d.readdata = {16'h0000, q.dirs};
        OUTPUT_LATCH_OFFSET: d.readdata = {16'h0000, q.outs};
        INPUT_STATE_OFFSET:  d.readdata = {16'h0000, q.filt};
        STATUS_OFFSET:       d.readdata = {29'h00000000, q.gave_zero, q.glitch, busy};
        RESULT_OFFSET:       d.readdata = {16'h0000, q.result};
        default:             d.readdata = 32'h00000000;
      endcase
    end
    if (acc_write && avs_address == DIRECTION_OFFSET) begin
      d.dirs = merge16(q.dirs, avs_writedata, avs_byteenable);
    end
    if (acc_write && avs_address == OUTPUT_LATCH_OFFSET) begin
      d.outs = merge16(q.outs, avs_writedata, avs_byteenable);
    end

    // sequencer
    unique case (q.fsm)
      ST_IDLE: begin
        // commands arriving while busy are dropped, not queued
        if (acc_write && avs_address == COMMAND_OFFSET && &avs_byteenable) begin
          d.op        = cmd.op;
          d.pin       = cmd.pin;
          d.level     = cmd.level;
          d.byte_mode = cmd.byte_mode;
          d.count     = cmd.arg;
          d.tick      = 32'h00000000;
          d.fsm       = ST_FETCH;
          unique case (cmd.op)
            OP_DRIVE_LOW: begin
              d.dirs = d.dirs | pin_mask(cmd.pin);
              d.outs = d.outs & ~pin_mask(cmd.pin);
            end
            OP_MAKE_OUTPUT: begin
              d.dirs = d.dirs | pin_mask(cmd.pin);
            end
            OP_RESTART: begin
              d.dirs = DIRECTION_RESET;
            end
            OP_MEASURE: begin
              d.dirs = d.dirs & ~pin_mask(cmd.pin);
            end
            default: begin
            end
          endcase
          if (cmd.op > OP_RESTART) begin
            d.fsm = ST_IDLE;                         // unknown opcode ignored
          end
        end
      end
      ST_FETCH: begin
        d.tick = q.tick + 32'h00000001;
        if (q.tick == 32'(FETCH_CYCLES_P - 1)) begin
          d.tick = 32'h00000000;
          d.fsm  = ST_IDLE;
          unique case (q.op)
            OP_NAP: begin
              d.count = 16'h0001 << q.count[2:0];
              d.fsm   = ST_NAP;
            end
            OP_DELAY: begin
              if (q.count != 16'h0000) begin
                d.fsm = ST_DELAY;
              end
            end
            OP_MEASURE: begin
              d.last_level = lvl;
              d.fsm        = ST_WAIT_EDGE;
            end
            default: begin
            end
          endcase
        end
      end
      ST_NAP: begin
        // raw watchdog quanta; no trim against the resonator here
        d.tick = q.tick + 32'h00000001;
        if (q.tick == 32'(NAP_BASE_CYCLES_P - 1)) begin
          d.tick  = 32'h00000000;
          d.count = q.count - 16'h0001;
          if (q.count == 16'h0001) begin
            d.glitch = 1'b1;
            d.fsm    = ST_WAKE;
          end
        end
      end
      ST_WAKE: begin
        d.tick = q.tick + 32'h00000001;
        if (q.tick == 32'(WAKE_GLITCH_CYCLES_P - 1)) begin
          d.glitch = 1'b0;
          d.tick   = 32'h00000000;
          d.fsm    = ST_IDLE;
        end
      end
      ST_DELAY: begin
        d.tick = q.tick + 32'h00000001;
        if (q.tick == 32'(MS_CYCLES_P - 1)) begin
          d.tick  = 32'h00000000;
          d.count = q.count - 16'h0001;
          if (q.count == 16'h0001) begin
            d.fsm = ST_IDLE;
          end
        end
      end
      ST_WAIT_EDGE: begin
        d.tick       = q.tick + 32'h00000001;
        d.last_level = lvl;
        // a level already present does not trigger; only a transition does
        if (lvl != q.last_level && lvl == q.level) begin
          d.tick  = 32'h00000000;
          d.count = 16'h0000;
          d.fsm   = ST_MEASURE;
        end else if (q.tick == 32'(EDGE_TIMEOUT_CYCLES_P - 1)) begin
          d.result    = 16'h0000;
          d.gave_zero = 1'b1;
          d.tick      = 32'h00000000;
          d.fsm       = ST_IDLE;
        end
      end
      ST_MEASURE: begin
        if (lvl != q.level) begin
          d.result    = q.byte_mode ? {8'h00, q.count[7:0]} : q.count;
          d.gave_zero = 1'b0;
          d.fsm       = ST_IDLE;
        end else begin
          d.tick = q.tick + 32'h00000001;
          if (q.tick == 32'(UNIT_CYCLES - 1)) begin
            d.tick = 32'h00000000;
            if (q.count == 16'hFFFF) begin
              // 16-bit counter would wrap: pulse too long
              d.result    = 16'h0000;
              d.gave_zero = 1'b1;
              d.fsm       = ST_IDLE;
            end else begin
              d.count = q.count + 16'h0001;
            end
          end
        end
      end
      default: begin
        d.fsm = ST_IDLE;
      end
    endcase
  end

  // ===========================================================================
  // state register
  // ===========================================================================
  always_ff @(posedge core_clk) begin
    if (reset) begin
      q      <= '0;
      q.fsm  <= ST_IDLE;
      q.dirs <= DIRECTION_RESET;
      q.outs <= OUTPUT_LATCH_RESET;
    end else begin
      q <= d;
    end
  end

  // ===========================================================================
  // checks
  // ===========================================================================
  logic cmd_take;
  assign cmd_take = acc_write && avs_address == COMMAND_OFFSET && &avs_byteenable
                    && q.fsm == ST_IDLE;

  property p_drive_low;
    @(posedge core_clk) disable iff (reset)
      (cmd_take && cmd.op == OP_DRIVE_LOW) |=>
        (q.dirs[$past(cmd.pin)] && !q.outs[$past(cmd.pin)] && q.fsm == ST_FETCH);
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("drive-low did not set pin");

  property p_released;
    @(posedge core_clk) disable iff (reset)
      (q.fsm == ST_WAKE) |-> (q.glitch && pin_drive.oe_n == 16'hFFFF);
  endproperty
  a_released: assert property (p_released) else $error("pin driven during wake glitch");

  property p_undriven;
    @(posedge core_clk) disable iff (reset)
      (q.fsm != ST_WAKE) |-> (pin_drive.oe_n == ~q.dirs);
  endproperty
  a_undriven: assert property (p_undriven) else $error("pin drive differs from direction");

  property p_make_output;
    @(posedge core_clk) disable iff (reset)
      (cmd_take && cmd.op == OP_MAKE_OUTPUT && !(avs_address == OUTPUT_LATCH_OFFSET)) |=>
        ($stable(q.outs) && q.dirs[$past(cmd.pin)]);
  endproperty
  a_make_output: assert property (p_make_output) else $error("make-output wrong");

  property p_restart;
    @(posedge core_clk) disable iff (reset)
      (cmd_take && cmd.op == OP_RESTART) |=> (q.dirs == 16'h0000);
  endproperty
  a_restart: assert property (p_restart) else $error("restart left an output");

  property p_measure_input;
    @(posedge core_clk) disable iff (reset)
      (cmd_take && cmd.op == OP_MEASURE) |=> !q.dirs[$past(cmd.pin)] ##1 !q.dirs[q.pin];
  endproperty
  a_measure_input: assert property (p_measure_input) else $error("measure pin not input");

  property p_no_level_start;
    @(posedge core_clk) disable iff (reset)
      (q.fsm == ST_WAIT_EDGE && lvl == q.last_level) |=> (q.fsm != ST_MEASURE);
  endproperty
  a_no_level_start: assert property (p_no_level_start) else $error("started without edge");

  // the start decision must have seen the other level first, then the chosen one
  property p_edge_start;
    @(posedge core_clk) disable iff (reset)
      (q.fsm == ST_WAIT_EDGE) ##1 (q.fsm == ST_MEASURE) |->
        ($past(lvl) == q.level && $past(q.last_level) != q.level);
  endproperty
  a_edge_start: assert property (p_edge_start) else $error("count began on wrong edge");

  property p_stop_on_change;
    @(posedge core_clk) disable iff (reset)
      (q.fsm == ST_MEASURE && lvl != q.level) |=> (q.fsm == ST_IDLE && !q.gave_zero);
  endproperty
  a_stop_on_change: assert property (p_stop_on_change) else $error("count ran past pin change");

  property p_unit_step;
    @(posedge core_clk) disable iff (reset)
      (q.fsm == ST_MEASURE && lvl == q.level && q.count != 16'hFFFF
       && q.tick == 32'(UNIT_CYCLES - 1)) |=>
        (q.fsm == ST_MEASURE && q.count == $past(q.count) + 16'h0001);
  endproperty
  a_unit_step: assert property (p_unit_step) else $error("width unit not counted");

  property p_edge_timeout;
    @(posedge core_clk) disable iff (reset)
      (q.fsm == ST_WAIT_EDGE && q.tick == 32'(EDGE_TIMEOUT_CYCLES_P - 1)
       && !(lvl != q.last_level && lvl == q.level)) |=>
        (q.fsm == ST_IDLE && q.gave_zero && q.result == 16'h0000);
  endproperty
  a_edge_timeout: assert property (p_edge_timeout) else $error("edge timeout not zero");

  property p_delay_end;
    @(posedge core_clk) disable iff (reset)
      (q.fsm == ST_DELAY && q.count == 16'h0001 && q.tick == 32'(MS_CYCLES_P - 1)) |=>
        (q.fsm == ST_IDLE);
  endproperty
  a_delay_end: assert property (p_delay_end) else $error("delay did not end");

  property p_byte_result;
    @(posedge core_clk) disable iff (reset)
      (q.fsm == ST_MEASURE && q.byte_mode && lvl != q.level) |=>
        (q.result == {8'h00, $past(q.count[7:0])} && q.fsm == ST_IDLE);
  endproperty
  a_byte_result: assert property (p_byte_result) else $error("byte result not low 8 bits");

  property p_nap_to_wake;
    @(posedge core_clk) disable iff (reset)
      (q.fsm == ST_NAP && q.count == 16'h0001 && q.tick == 32'(NAP_BASE_CYCLES_P - 1)) |=>
        (q.fsm == ST_WAKE && q.glitch && pin_drive.oe_n == 16'hFFFF);
  endproperty
  a_nap_to_wake: assert property (p_nap_to_wake) else $error("nap end missed wake");

  property p_bus_answer;
    @(posedge core_clk) disable iff (reset)
      ($rose(req) && !q.ack) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer not in one cycle");

  c_measure_done: cover property (@(posedge core_clk) disable iff (reset)
    q.fsm == ST_MEASURE ##1 q.fsm == ST_IDLE);
  c_edge_timeout: cover property (@(posedge core_clk) disable iff (reset)
    q.fsm == ST_WAIT_EDGE ##1 (q.fsm == ST_IDLE && q.gave_zero));
  c_wake_glitch: cover property (@(posedge core_clk) disable iff (reset)
    $fell(q.glitch));
  c_delay_done: cover property (@(posedge core_clk) disable iff (reset)
    q.fsm == ST_DELAY ##1 q.fsm == ST_IDLE);

endmodule // pin_control_pulse_timing
`default_nettype wire

// *** verilog/pin_timing_pkg.sv ***
`default_nettype none
package pin_timing_pkg;

  // ===========================================================================
  // timing, all derived from the 125 MHz core clock
  // ===========================================================================
  localparam int CLK_PERIOD_NS        = 8;
  localparam int UNIT_TIME_NS         = 2000;       // width unit, 2 us
  localparam int UNIT_CYCLES          = UNIT_TIME_NS / CLK_PERIOD_NS;
  localparam int MS_TIME_NS           = 1000000;
  localparam int MS_CYCLES            = MS_TIME_NS / CLK_PERIOD_NS;
  localparam int FETCH_TIME_NS        = 300000;     // 0.3 ms per instruction
  localparam int FETCH_CYCLES         = (FETCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NAP_BASE_TIME_NS     = 18000000;   // 18 ms nap quantum
  localparam int NAP_BASE_CYCLES      = NAP_BASE_TIME_NS / CLK_PERIOD_NS;
  localparam int WAKE_GLITCH_TIME_NS  = 18000000;   // pins released on wake
  localparam int WAKE_GLITCH_CYCLES   = WAKE_GLITCH_TIME_NS / CLK_PERIOD_NS;
  localparam int EDGE_TIMEOUT_TIME_NS = 131000000;  // 0.131 s
  localparam int EDGE_TIMEOUT_CYCLES  = EDGE_TIMEOUT_TIME_NS / CLK_PERIOD_NS;

  // ===========================================================================
  // register map, byte addresses
  // ===========================================================================
  localparam logic [4:0] DIRECTION_OFFSET    = 5'h00;
  localparam logic [4:0] OUTPUT_LATCH_OFFSET = 5'h04;
  localparam logic [4:0] INPUT_STATE_OFFSET  = 5'h08;
  localparam logic [4:0] COMMAND_OFFSET      = 5'h0C;
  localparam logic [4:0] STATUS_OFFSET       = 5'h10;
  localparam logic [4:0] RESULT_OFFSET       = 5'h14;
  localparam int STATUS_BUSY_BIT   = 0;
  localparam int STATUS_WAKE_BIT   = 1;
  localparam int STATUS_ZERO_BIT   = 2;
  localparam logic [15:0] DIRECTION_RESET    = 16'h0000;
  localparam logic [15:0] OUTPUT_LATCH_RESET = 16'h0000;

  // ===========================================================================
  // types
  // ===========================================================================
  typedef enum logic [2:0] {
    OP_DRIVE_LOW   = 3'h0,
    OP_MAKE_OUTPUT = 3'h1,
    OP_NAP         = 3'h2,
    OP_DELAY       = 3'h3,
    OP_MEASURE     = 3'h4,
    OP_RESTART     = 3'h5
  } op_type;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'h0,
    ST_FETCH     = 3'h1,
    ST_NAP       = 3'h2,
    ST_WAKE      = 3'h3,
    ST_DELAY     = 3'h4,
    ST_WAIT_EDGE = 3'h5,
    ST_MEASURE   = 3'h6
  } fsm_type;

  // command word layout as written to the command register
  typedef struct packed {
    logic [15:0] arg;
    logic [5:0]  spare_hi;
    logic        byte_mode;
    logic        level;
    logic [3:0]  pin;
    logic        spare_lo;
    logic [2:0]  op;
  } cmd_type;

  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe_n;
  } pin_drive_type;

  typedef struct packed {
    fsm_type     fsm;
    logic [2:0]  op;
    logic [15:0] dirs;
    logic [15:0] outs;
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic [15:0] sync3;
    logic [15:0] filt;
    logic [31:0] tick;
    logic [15:0] count;
    logic [3:0]  pin;
    logic        level;
    logic        byte_mode;
    logic        last_level;
    logic [15:0] result;
    logic        gave_zero;
    logic        glitch;
    logic        ack;
    logic [31:0] readdata;
  } state_type;

endpackage
`default_nettype wire
